// ===== rtl/mfa_fault_alert.sv
// monitor fault flags and open-drain alert output.
// assumes results arrive with a one-cycle conv_done_i pulse from the
// sequencer on ref_clk_i, and the register port on the same clock.
`timescale 1ns/1ps
module mfa_fault_alert (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  output logic reg_rvalid_o,
  input wire logic conv_done_i,
  input wire logic [31:0] rail_result_i,
  input wire logic [7:0] temp_result_i,
  output logic monitor_run_o,
  input wire logic alert_n_i,
  output logic alert_n_o,
  output logic alert_oe_o
);
  mfa_pkg::mfa_state_t s_r, s_nxt;
  logic [mfa_pkg::NUM_RAILS-1:0] rail_bad;
  logic temp_over_hot, temp_under_hyst, running, rd_flags, temp_evt;
  logic [7:0] new_flags, rd_mux;
  mfa_pkg::mfa_mode_t mode;

  genvar g;
  generate
    for (g = 0; g < mfa_pkg::NUM_RAILS; g++) begin : g_rail
      assign rail_bad[g] = rail_result_i[8*g +: 8] <
          s_r.vlim[g].voltage_low_limit ||
          rail_result_i[8*g +: 8] > s_r.vlim[g].voltage_high_limit;
    end
  endgenerate

  assign mode = mfa_pkg::mfa_mode_t'(s_r.temp_irq_behaviour[1:0]);
  assign temp_over_hot = $signed(temp_result_i) >
      $signed(s_r.temp_hot);
  assign temp_under_hyst = $signed(temp_result_i) < $signed(s_r.temp_hyst);
  // monitoring halts when stopped or while the alert clear bit is set
  assign running = s_r.config_r[mfa_pkg::CFG_START] &&
      !s_r.config_r[mfa_pkg::CFG_ALERT_CLR];
  assign rd_flags = reg_rd_i && reg_addr_i == mfa_pkg::OFS_FAULT_FLAGS;

  always_comb begin
    rd_mux = mfa_pkg::RST_ZERO;
    case (reg_addr_i)
      mfa_pkg::OFS_CONFIG: rd_mux = s_r.config_r;
      mfa_pkg::OFS_FAULT_FLAGS: rd_mux = s_r.fault_flags;
      mfa_pkg::OFS_FAULT_MASK: rd_mux = s_r.fault_source_mask;
      mfa_pkg::OFS_TEMP_BEHAV: rd_mux = s_r.temp_irq_behaviour;
      mfa_pkg::OFS_TEMP_HOT: rd_mux = s_r.temp_hot;
      mfa_pkg::OFS_TEMP_HYST: rd_mux = s_r.temp_hyst;
      mfa_pkg::OFS_TRES: rd_mux = s_r.tres;
      default: begin
        for (int i = 0; i < mfa_pkg::NUM_RAILS; i++) begin
          if (reg_addr_i == mfa_pkg::OFS_VLIM_FIRST + 8'(2*i))
            rd_mux = s_r.vlim[i].voltage_high_limit;
          if (reg_addr_i == mfa_pkg::OFS_VLIM_FIRST + 8'(2*i+1))
            rd_mux = s_r.vlim[i].voltage_low_limit;
          if (reg_addr_i == mfa_pkg::OFS_VRES_FIRST + 8'(i))
            rd_mux = s_r.vres[i];
        end
      end
    endcase
  end

  always_comb begin
    s_nxt = s_r;
    s_nxt.rvalid = reg_rd_i;
    s_nxt.rdata = reg_rd_i ? rd_mux : s_r.rdata;
    new_flags = mfa_pkg::RST_ZERO;
    temp_evt = 1'b0;
    if (conv_done_i && running) begin
      s_nxt.vres = rail_result_i;
      s_nxt.tres = temp_result_i;
      new_flags[mfa_pkg::NUM_RAILS-1:0] = rail_bad;
      case (mode)
        mfa_pkg::MFA_MODE_ONETIME: begin
          // armed for hot; after a hot event the next event is on cooling
          if (s_r.temp_armed_hot && temp_over_hot) begin
            temp_evt = 1'b1;
            s_nxt.temp_armed_hot = 1'b0;
          end else if (!s_r.temp_armed_hot && temp_under_hyst) begin
            temp_evt = 1'b1;
            s_nxt.temp_armed_hot = 1'b1;
          end
        end
        mfa_pkg::MFA_MODE_COMPARATOR: begin
          temp_evt = temp_over_hot;
          s_nxt.temp_cmp_fault = temp_over_hot;
          s_nxt.temp_armed_hot = 1'b1;
        end
        default: begin
          // hot sets the fault, which repeats until below hysteresis
          if (temp_over_hot)
            s_nxt.temp_cmp_fault = 1'b1;
          else if (temp_under_hyst)
            s_nxt.temp_cmp_fault = 1'b0;
          temp_evt = temp_over_hot ||
              (s_r.temp_cmp_fault && !temp_under_hyst);
          s_nxt.temp_armed_hot = 1'b1;
        end
      endcase
      new_flags[mfa_pkg::FLAG_TEMP] = temp_evt;
      new_flags = new_flags & ~s_r.fault_source_mask;
    end
    if (mode != mfa_pkg::MFA_MODE_COMPARATOR)
      s_nxt.temp_cmp_fault = s_nxt.temp_cmp_fault &&
          mode != mfa_pkg::MFA_MODE_ONETIME;
    if (rd_flags) begin
      // temperature bit survives a read only in comparator mode
      if (mode == mfa_pkg::MFA_MODE_COMPARATOR && s_r.temp_cmp_fault)
        s_nxt.fault_flags = s_r.fault_flags &
            (8'h01 << mfa_pkg::FLAG_TEMP);
      else
        s_nxt.fault_flags = mfa_pkg::RST_ZERO;
    end
    // a new event in the read cycle wins over the clear
    s_nxt.fault_flags = (s_nxt.fault_flags | new_flags) &
        mfa_pkg::FLAGS_USED;
    if (reg_wr_i) begin
      case (reg_addr_i)
        mfa_pkg::OFS_CONFIG:
          s_nxt.config_r = reg_wdata_i & mfa_pkg::CONFIG_USED;
        mfa_pkg::OFS_FAULT_MASK:
          s_nxt.fault_source_mask = reg_wdata_i & mfa_pkg::FLAGS_USED;
        mfa_pkg::OFS_TEMP_BEHAV:
          s_nxt.temp_irq_behaviour = reg_wdata_i & mfa_pkg::BEHAV_USED;
        mfa_pkg::OFS_TEMP_HOT: s_nxt.temp_hot = reg_wdata_i;
        mfa_pkg::OFS_TEMP_HYST: s_nxt.temp_hyst = reg_wdata_i;
        default: begin
          for (int i = 0; i < mfa_pkg::NUM_RAILS; i++) begin
            if (reg_addr_i == mfa_pkg::OFS_VLIM_FIRST + 8'(2*i))
              s_nxt.vlim[i].voltage_high_limit = reg_wdata_i;
            if (reg_addr_i == mfa_pkg::OFS_VLIM_FIRST + 8'(2*i+1))
              s_nxt.vlim[i].voltage_low_limit = reg_wdata_i;
          end
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (rst_i || s_r.config_r[mfa_pkg::CFG_SOFT_RST]) begin
      s_r <= '0;
      s_r.config_r <= mfa_pkg::RST_CONFIG;
      s_r.temp_hot <= mfa_pkg::RST_TEMP_HOT;
      s_r.temp_hyst <= mfa_pkg::RST_TEMP_HYST;
      s_r.temp_armed_hot <= 1'b1;
      for (int i = 0; i < mfa_pkg::NUM_RAILS; i++) begin
        s_r.vlim[i].voltage_high_limit <= mfa_pkg::RST_VOLTAGE_HIGH_LIMIT;
        s_r.vlim[i].voltage_low_limit <= mfa_pkg::RST_VOLTAGE_LOW_LIMIT;
      end
    end else begin
      s_r <= s_nxt;
    end
  end

  logic alert_act;
  logic [7:0] flag_alert_sel;
  // in comparator mode the sticky temperature flag does not hold the line;
  // the live fault does, so the line is released as soon as it goes away
  assign flag_alert_sel = (mode == mfa_pkg::MFA_MODE_COMPARATOR) ?
      ~(8'h01 << mfa_pkg::FLAG_TEMP) : mfa_pkg::FLAGS_USED;
  // clear bit releases the line but leaves the flags untouched
  assign alert_act = s_r.config_r[mfa_pkg::CFG_ALERT_EN] &&
      !s_r.config_r[mfa_pkg::CFG_ALERT_CLR] &&
      (|(s_r.fault_flags & ~s_r.fault_source_mask & flag_alert_sel) ||
       (mode == mfa_pkg::MFA_MODE_COMPARATOR && s_r.temp_cmp_fault &&
        !s_r.fault_source_mask[mfa_pkg::FLAG_TEMP]));
  // open drain: only ever drive low
  assign alert_n_o = 1'b0;
  assign alert_oe_o = alert_act;
  assign reg_rdata_o = s_r.rdata;
  assign reg_rvalid_o = s_r.rvalid;
  assign monitor_run_o = running;
endmodule // mfa_fault_alert

// ===== rtl/mfa_pkg.sv
// package for the monitor fault and alert block: register offsets,
// field positions, reset values, temperature modes, carrier structs.
// assumes a register port of byte offset, strobes and 8-bit data.
// Overview of operation
// - status bits 0-3 are rail faults, bit 4 temperature, 5-7 reserved zero
// - voltage result below low or above high limit flags fault and alert
// - hot temperature limit resets to 0x50, plus 80 degrees
// - temperature hysteresis limit resets to 0x41, plus 65 degrees
// - voltage limits reset to 1.1 and 0.9 times nominal code
// - status register resets to zero, read only, read may clear it
// - mask bit one suppresses that flag and its alert; mask resets zero
// - temperature config bits 1:0 pick default, one-time, comparator modes
// - default and one-time modes: status read clears flags and alert
// - comparator mode: alert releases only when temperature fault disappears
// - read while temperature fault persists clears all but bit 4
// - read after fault is gone clears every flag
// - persisting fault reasserts alert at next completed conversion
// - configuration bit 1 low holds alert inactive
// - alerts never stop measurement; results keep updating and readable
// - alert line is only pulled low or released, never driven high
// - temperature above hot limit starts a temperature interrupt in all modes
// - default mode re-raises on each measurement until below hysteresis
// - one-time mode: after clear, next interrupt when below hysteresis
// - comparator mode holds alert low while temperature above hot
// - config bit 3 releases alert, keeps status, and halts monitoring
package mfa_pkg;
  localparam logic [7:0] OFS_CONFIG = 8'h40;
  localparam logic [7:0] OFS_FAULT_FLAGS = 8'h41;
  localparam logic [7:0] OFS_FAULT_MASK = 8'h43;
  localparam logic [7:0] OFS_TEMP_BEHAV = 8'h4b;
  localparam logic [7:0] OFS_TEMP_HOT = 8'h39;
  localparam logic [7:0] OFS_TEMP_HYST = 8'h3a;
  localparam logic [7:0] OFS_VLIM_FIRST = 8'h2b;
  localparam logic [7:0] OFS_VLIM_LAST = 8'h32;
  localparam logic [7:0] OFS_VRES_FIRST = 8'h20;
  localparam logic [7:0] OFS_TRES = 8'h27;
  localparam int NUM_RAILS = 4;
  localparam int FLAG_TEMP = 4;
  localparam int CFG_START = 0;
  localparam int CFG_ALERT_EN = 1;
  localparam int CFG_ALERT_CLR = 3;
  localparam int CFG_SOFT_RST = 7;
  localparam logic [7:0] RST_CONFIG = 8'h08;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam logic [7:0] RST_TEMP_HOT = 8'h50;
  localparam logic [7:0] RST_TEMP_HYST = 8'h41;
  // nominal code is 192; 1.1x gives 211, 0.9x gives 172 (8-bit codes)
  localparam logic [7:0] RST_VOLTAGE_HIGH_LIMIT = 8'hd3;
  localparam logic [7:0] RST_VOLTAGE_LOW_LIMIT = 8'hac;
  localparam logic [7:0] FLAGS_USED = 8'h1f;
  localparam logic [7:0] BEHAV_USED = 8'h03;
  localparam logic [7:0] CONFIG_USED = 8'hbb;

  typedef enum logic [1:0] {
    MFA_MODE_DEFAULT = 2'b00,
    MFA_MODE_ONETIME = 2'b01,
    MFA_MODE_COMPARATOR = 2'b10,
    MFA_MODE_DEFAULT2 = 2'b11
  } mfa_mode_t;

  typedef struct packed {
    logic [7:0] voltage_high_limit;
    logic [7:0] voltage_low_limit;
  } mfa_vlim_t;

  typedef struct packed {
    logic [7:0] config_r;
    logic [7:0] fault_flags;
    logic [7:0] fault_source_mask;
    logic [7:0] temp_irq_behaviour;
    logic [7:0] temp_hot;
    logic [7:0] temp_hyst;
    mfa_vlim_t [NUM_RAILS-1:0] vlim;
    logic [NUM_RAILS-1:0][7:0] vres;
    logic [7:0] tres;
    logic temp_armed_hot;
    logic temp_cmp_fault;
    logic [7:0] rdata;
    logic rvalid;
  } mfa_state_t;
endpackage

// ===== verif/mfa_fault_alert_chk.sv
// port assertions for the fault and alert block
// assumes one clock domain and binding onto mfa_fault_alert
`timescale 1ns/1ps
module mfa_fault_alert_chk (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [7:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic reg_rvalid_o,
  input wire logic conv_done_i,
  input wire logic monitor_run_o,
  input wire logic alert_n_o,
  input wire logic alert_oe_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  a_read_answer: assert property (reg_rd_i |=> reg_rvalid_o)
    else $error("read got no answer");
  a_never_high: assert property (alert_n_o == 1'b0)
    else $error("alert driven high");
  a_flags_reserved: assert property (reg_rd_i &&
    reg_addr_i == mfa_pkg::OFS_FAULT_FLAGS |=> reg_rdata_o[7:5] == 3'h0)
    else $error("reserved flag bits set");
  a_clear_halts: assert property (reg_wr_i &&
    reg_addr_i == mfa_pkg::OFS_CONFIG && reg_wdata_i[3]
    |=> !monitor_run_o && !alert_oe_o)
    else $error("clear bit did not halt");
  a_enable_off: assert property (reg_wr_i &&
    reg_addr_i == mfa_pkg::OFS_CONFIG && !reg_wdata_i[1] |=> !alert_oe_o)
    else $error("alert with enable off");
  a_run_start: assert property (reg_wr_i &&
    reg_addr_i == mfa_pkg::OFS_CONFIG && reg_wdata_i[0] &&
    !reg_wdata_i[3] && !reg_wdata_i[7] |=> monitor_run_o)
    else $error("monitor did not start");
  a_alert_quiet: assert property (!$past(reg_rd_i) &&
    !$past(reg_wr_i) && !$past(conv_done_i) |-> $stable(alert_oe_o))
    else $error("alert moved without cause");
  a_rdata_hold: assert property (!$past(reg_rd_i) |->
    $stable(reg_rdata_o))
    else $error("read data moved");
endmodule // mfa_fault_alert_chk

bind mfa_fault_alert mfa_fault_alert_chk u_chk (.*);

// ===== verif/mfa_alert_line.sv
// wired interrupt line shared by open-drain devices
// assumes a pull-up; the block's enable is high while it pulls low
`timescale 1ns/1ps
module mfa_alert_line (
  input wire logic dut_oe_i,
  input wire logic dut_n_i,
  output logic line_n_o
);
  // nobody drives high, so released means pulled up
  assign line_n_o = (dut_oe_i && !dut_n_i) ? 1'b0 : 1'b1;
endmodule // mfa_alert_line

// ===== verif/mfa_fault_alert_tb.sv
// self-checking bench for the fault and alert block
// assumes a 40 MHz clock; inputs change at the falling edge
`timescale 1ns/1ps
module mfa_fault_alert_tb;
  logic clk = 0, rst = 1, wr = 0, rd = 0, cd = 0;
  logic [7:0] addr = 0, wd = 0, tres = 8'h30, rdat;
  logic [31:0] rails = 32'hc0c0c0c0;
  logic rv, run, an, oe, line;
  int err_count = 0, checked = 0, cyc = 0;
  always #12.5 clk = ~clk;
  mfa_fault_alert u_dut (.ref_clk_i(clk), .rst_i(rst), .reg_addr_i(addr),
    .reg_wr_i(wr), .reg_rd_i(rd), .reg_wdata_i(wd), .reg_rdata_o(rdat),
    .reg_rvalid_o(rv), .conv_done_i(cd), .rail_result_i(rails),
    .temp_result_i(tres), .monitor_run_o(run), .alert_n_i(line),
    .alert_n_o(an), .alert_oe_o(oe));
  mfa_alert_line u_line (.dut_oe_i(oe), .dut_n_i(an), .line_n_o(line));
  task automatic chk(input logic [7:0] g, e);
    checked++;
    if (g !== e) begin
      err_count++;
      $display("BAD %0t %h %h", $time, g, e);
    end
  endtask
  task automatic wreg(input logic [7:0] a, d);
    addr = a; wd = d; wr = 1;
    @(negedge clk) wr = 0;
    @(negedge clk);
  endtask
  task automatic rreg(input logic [7:0] a, e);
    addr = a; rd = 1;
    @(negedge clk) rd = 0;
    chk({7'h0, rv}, 8'h01);
    chk(rdat, e);
    @(negedge clk);
  endtask
  task automatic conv(input logic [31:0] r, input logic [7:0] t);
    rails = r; tres = t; cd = 1;
    @(negedge clk) cd = 0;
    @(negedge clk);
  endtask
  task automatic t_reset;
    logic [7:0] a[8] = '{8'h41, 8'h43, 8'h4b, 8'h39, 8'h3a, 8'h2b, 8'h2c,
      8'h40};
    logic [7:0] e[8] = '{8'h00, 8'h00, 8'h00, 8'h50, 8'h41, 8'hd3, 8'hac,
      8'h08};
    for (int i = 0; i < 8; i++) rreg(a[i], e[i]);
    wreg(8'h41, 8'hff);
    rreg(8'h41, 8'h00);
    rreg(8'h00, 8'h00);
  endtask
  task automatic t_volt;
    wreg(8'h40, 8'h03);
    conv(32'hc0c0ff00, 8'h30);
    chk({7'h0, line}, 8'h00);
    rreg(8'h41, 8'h03);
    chk({7'h0, line}, 8'h01);
    conv(32'hc0c0ff00, 8'h30);
    chk({7'h0, line}, 8'h00);
    rreg(8'h20, 8'h00);
    rreg(8'h41, 8'h03);
    wreg(8'h43, 8'h01);
    conv(32'hc0c0ff00, 8'h30);
    rreg(8'h41, 8'h02);
    wreg(8'h43, 8'h00);
    wreg(8'h40, 8'h01);
    conv(32'hc0c0ff00, 8'h30);
    chk({7'h0, line}, 8'h01);
    wreg(8'h40, 8'h0b);
    chk({7'h0, run}, 8'h00);
    rreg(8'h41, 8'h03);
    wreg(8'h40, 8'h03);
    conv(32'hc0c0c0c0, 8'h30);
    rreg(8'h41, 8'h00);
  endtask
  task automatic t_temp;
    for (int m = 0; m < 4; m++) begin
      wreg(8'h4b, 8'(m));
      conv(32'hc0c0c0c0, 8'h60);
      chk({7'h0, line}, 8'h00);
      rreg(8'h41, 8'h10);
      if (m == 2) begin
        chk({7'h0, line}, 8'h00);
        rreg(8'h41, 8'h10);
        conv(32'hc0c0c0c0, 8'h30);
        chk({7'h0, line}, 8'h01);
        rreg(8'h41, 8'h10);
        rreg(8'h41, 8'h00);
      end else begin
        chk({7'h0, line}, 8'h01);
        conv(32'hc0c0c0c0, 8'h60);
        rreg(8'h41, (m == 1) ? 8'h00 : 8'h10);
        conv(32'hc0c0c0c0, 8'h30);
        rreg(8'h41, (m == 1) ? 8'h10 : 8'h00);
      end
    end
  endtask
  task automatic stop_test;
    if (err_count == 0 && checked > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  // ceiling sits well above the roughly 130 cycles the tests need
  always @(posedge clk) begin
    cyc++;
    if (cyc == 4000) begin
      err_count++;
      stop_test();
    end
  end
  initial begin
    repeat (16) @(negedge clk);
    rst = 0;
    t_reset();
    t_volt();
    t_temp();
    stop_test();
  end
endmodule // mfa_fault_alert_tb
